// ### shared/fb_regs_pkg.sv
package fb_regs_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [5:0] IX_FB_HIGH = 6'h22;
  localparam logic [5:0] IX_FB_LOW = 6'h24;
  localparam logic [5:0] IX_SEED_CTL = 6'h25;
  localparam logic [5:0] IX_DEN_HIGH = 6'h26;
  localparam logic [5:0] IX_DEN_LOW = 6'h27;
  localparam logic [5:0] IX_SEED_HIGH = 6'h28;
  localparam logic [5:0] IX_SEED_LOW = 6'h29;
  localparam logic [5:0] IX_NUM_HIGH = 6'h2A;
  localparam logic [5:0] IX_NUM_LOW = 6'h2B;
  localparam logic [5:0] IX_OUT_MOD = 6'h2C;
  localparam logic [5:0] IX_OUT_ASEL = 6'h2D;
  localparam logic [5:0] IX_OUT_BSEL = 6'h2E;
  localparam logic [5:0] IX_PIN_CFG = 6'h3A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_SEED_EN = 15;
  localparam int POS_PFD_DLY = 8;
  localparam int POS_OUT_A_POWER_LEVEL = 8;
  localparam int POS_OUT_B_POWERDOWN = 7;
  localparam int POS_OUT_A_POWERDOWN = 6;
  localparam int POS_MOD_RUN = 5;
  localparam int POS_OUTA_SEL = 11;
  localparam int POS_BOOST = 9;
  localparam int POS_PIN_IGN = 15;
  localparam int POS_PIN_HYST = 14;
  localparam int POS_PIN_LVL = 12;
  localparam int POS_PIN_FMT = 9;

  // ----------------------------------------
  // Reset and fixed values
  // ----------------------------------------
  localparam logic [18:0] RST_N = 19'h00064;
  localparam logic [5:0] RST_PFD_DLY = 6'h02;
  localparam logic [31:0] RST_DEN = 32'hFFFFFFFF;
  localparam logic [5:0] RST_PWR = 6'h1F;
  localparam logic RST_OUT_B_POWERDOWN = 1'h1;
  localparam logic RST_MOD_RUN = 1'h1;
  localparam logic [1:0] RST_SEL = 2'h1;
  localparam logic RST_PIN_IGN = 1'h1;
  localparam logic [15:0] FIX_SEED_CTL = 16'h0004;
  localparam logic [15:0] FIX_OUT_ASEL = 16'hC0C0;
  localparam logic [15:0] FIX_OUT_BSEL = 16'h07FC;
  localparam logic [15:0] FIX_PIN_CFG = 16'h0001;

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [2:0] ORDER_MAX = 3'h4;
  localparam logic [2:0] FMT_MAX = 3'h3;
  localparam logic [1:0] SEL_SPECIAL = 2'h2;
  localparam logic [1:0] SEL_HIZ = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_state_e;

  typedef struct packed {
    logic [18:0] feedbackDivide;
    logic [31:0] fractionNumerator;
    logic [31:0] fractionDenominator;
    logic [31:0] modulatorSeed;
    logic [2:0] modulatorOrder;
    logic modulatorRun;
    logic [5:0] phaseDetectorDelaySelect;
    logic [5:0] outAPowerLevel;
    logic [5:0] outBPowerLevel;
    logic outAPowerdown;
    logic outBPowerdown;
    logic [1:0] outASourceSelect;
    logic [1:0] outBSourceSelect;
    logic [1:0] outputCurrentBoost;
    logic inputPinHysteresis;
    logic [1:0] inputPinBiasLevel;
    logic syncLvds;
    logic sysrefRequestLvds;
  } synth_cfg_s;

endpackage

// ### hdl/cfg_field.sv
`timescale 1ns/100ps
module cfg_field #(
  parameter int W = 1,
  parameter int LSB = 0,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [W-1:0] q
);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q <= RST;
    end else if (we) begin
      q <= wdata[LSB +: W];
    end
  end

endmodule // cfg_field

// ### hdl/seed_accum.sv
`timescale 1ns/100ps
module seed_accum (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic addHigh,
  input wire logic addLow,
  input wire logic [15:0] addVal,
  output logic [31:0] seed
);

  // Clear wins over a write in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn || clear) begin
      seed <= 32'h00000000;
    end else if (addHigh) begin
      seed <= seed + {addVal, 16'h0000};
    end else if (addLow) begin
      seed <= seed + {16'h0000, addVal};
    end
  end

endmodule // seed_accum

// ### hdl/feedback_divider_mash_output_regs.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module feedback_divider_mash_output_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic doublerEnable,
  input wire logic sysrefOutputEnable,
  input wire logic phaseSyncMode,
  input wire logic syncPin,
  input wire logic sysrefRequestPin,
  output fb_regs_pkg::synth_cfg_s synthCfg,
  output logic syncUsed,
  output logic sysrefRequestUsed
);
  import fb_regs_pkg::*;

  apb_state_e st_q;
  apb_state_e st_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [5:0] idx;
  logic accessCyc;
  logic commit;
  logic rdHit;
  logic [15:0] rdWord;
  logic [63:0] wrIdx;
  logic [2:0] nHi_q;
  logic [15:0] nLo_q;
  logic seedEn_q;
  logic [5:0] pfdDly_q;
  logic [15:0] denHi_q;
  logic [15:0] denLo_q;
  logic [15:0] numHi_q;
  logic [15:0] numLo_q;
  logic [31:0] seedAcc;
  logic [5:0] outAPwr_q;
  logic [5:0] outBPwr_q;
  logic outBPd_q;
  logic outAPd_q;
  logic modRun_q;
  logic [2:0] modOrder_q;
  logic [1:0] outASel_q;
  logic [1:0] boost_q;
  logic [1:0] outBSel_q;
  logic pinIgn_q;
  logic pinHyst_q;
  logic [1:0] pinLvl_q;
  logic [2:0] pinFmt_q;
  logic pinsLive;
  synth_cfg_s cfg_d;
  synth_cfg_s cfg_q;
  logic syncUsed_q;
  logic sysrefReqUsed_q;

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign idx = paddr[7:2];
  assign accessCyc = psel && penable;
  assign commit = accessCyc && (st_q == ST_DONE);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (accessCyc) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= (st_q == ST_IDLE) && accessCyc;
      pslverr_q <= (st_q == ST_IDLE) && accessCyc && !rdHit;
      if ((st_q == ST_IDLE) && accessCyc) begin
        prdata_q <= (pwrite || !rdHit) ? 32'h00000000
                                       : {16'h0000, rdWord};
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  always_comb begin
    wrIdx = '0;
    if (commit && pwrite && rdHit) begin
      wrIdx[idx] = 1'b1;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always_comb begin
    rdHit = (paddr[1:0] == 2'h0);
    rdWord = 16'h0000;
    case (idx)
      IX_FB_HIGH: rdWord = {13'h0000, nHi_q};
      IX_FB_LOW: rdWord = nLo_q;
      IX_SEED_CTL: rdWord = FIX_SEED_CTL |
        {seedEn_q, 1'b0, pfdDly_q, 8'h00};
      IX_DEN_HIGH: rdWord = denHi_q;
      IX_DEN_LOW: rdWord = denLo_q;
      IX_SEED_HIGH: rdWord = seedAcc[31:16];
      IX_SEED_LOW: rdWord = seedAcc[15:0];
      IX_NUM_HIGH: rdWord = numHi_q;
      IX_NUM_LOW: rdWord = numLo_q;
      IX_OUT_MOD: rdWord = {2'h0, outAPwr_q, outBPd_q, outAPd_q,
        modRun_q, 2'h0, modOrder_q};
      IX_OUT_ASEL: rdWord = FIX_OUT_ASEL |
        {3'h0, outASel_q, boost_q, 3'h0, outBPwr_q};
      IX_OUT_BSEL: rdWord = FIX_OUT_BSEL | {14'h0000, outBSel_q};
      IX_PIN_CFG: rdWord = FIX_PIN_CFG |
        {pinIgn_q, pinHyst_q, pinLvl_q, pinFmt_q, 9'h000};
      default: rdHit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Divider and fraction fields
  // ----------------------------------------
  // divide value high bits
  cfg_field #(.W(3), .LSB(0), .RST(RST_N[18:16])) uNHi (.mclk(mclk),
    .resetn(resetn), .we(wrIdx[IX_FB_HIGH]), .wdata(pwdata[15:0]),
    .q(nHi_q));
  cfg_field #(.W(16), .LSB(0), .RST(RST_N[15:0])) uNLo (.mclk(mclk),
    .resetn(resetn), .we(wrIdx[IX_FB_LOW]), .wdata(pwdata[15:0]),
    .q(nLo_q));
  cfg_field #(.W(16), .LSB(0), .RST(RST_DEN[31:16])) uDenHi (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_DEN_HIGH]),
    .wdata(pwdata[15:0]), .q(denHi_q));
  cfg_field #(.W(16), .LSB(0), .RST(RST_DEN[15:0])) uDenLo (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_DEN_LOW]),
    .wdata(pwdata[15:0]), .q(denLo_q));
  cfg_field #(.W(16), .LSB(0), .RST(16'h0000)) uNumHi (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_NUM_HIGH]),
    .wdata(pwdata[15:0]), .q(numHi_q));
  cfg_field #(.W(16), .LSB(0), .RST(16'h0000)) uNumLo (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_NUM_LOW]),
    .wdata(pwdata[15:0]), .q(numLo_q));

  // ----------------------------------------
  // Modulator fields
  // ----------------------------------------
  // seed enable bit
  cfg_field #(.W(1), .LSB(POS_SEED_EN), .RST(1'h0)) uSeedEn (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_SEED_CTL]),
    .wdata(pwdata[15:0]), .q(seedEn_q));
  cfg_field #(.W(6), .LSB(POS_PFD_DLY), .RST(RST_PFD_DLY)) uPfd (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_SEED_CTL]),
    .wdata(pwdata[15:0]), .q(pfdDly_q));
  cfg_field #(.W(1), .LSB(POS_MOD_RUN), .RST(RST_MOD_RUN)) uRun (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_MOD]),
    .wdata(pwdata[15:0]), .q(modRun_q));
  cfg_field #(.W(3), .LSB(0), .RST(3'h0)) uOrder (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_MOD]),
    .wdata(pwdata[15:0]), .q(modOrder_q));
  seed_accum uSeed (
    .mclk(mclk),
    .resetn(resetn),
    .clear(!modRun_q),
    .addHigh(wrIdx[IX_SEED_HIGH]),
    .addLow(wrIdx[IX_SEED_LOW]),
    .addVal(pwdata[15:0]),
    .seed(seedAcc)
  );

  // ----------------------------------------
  // Output fields
  // ----------------------------------------
  // output A power
  cfg_field #(.W(6), .LSB(POS_OUT_A_POWER_LEVEL), .RST(RST_PWR)) uAPwr (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_MOD]),
    .wdata(pwdata[15:0]), .q(outAPwr_q));
  cfg_field #(.W(1), .LSB(POS_OUT_B_POWERDOWN), .RST(RST_OUT_B_POWERDOWN)) uBPd (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_MOD]),
    .wdata(pwdata[15:0]), .q(outBPd_q));
  cfg_field #(.W(1), .LSB(POS_OUT_A_POWERDOWN), .RST(1'h0)) uAPd (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_MOD]),
    .wdata(pwdata[15:0]), .q(outAPd_q));
  cfg_field #(.W(2), .LSB(POS_OUTA_SEL), .RST(RST_SEL)) uASel (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_ASEL]),
    .wdata(pwdata[15:0]), .q(outASel_q));
  cfg_field #(.W(2), .LSB(POS_BOOST), .RST(2'h0)) uBoost (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_ASEL]),
    .wdata(pwdata[15:0]), .q(boost_q));
  cfg_field #(.W(6), .LSB(0), .RST(RST_PWR)) uBPwr (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_ASEL]),
    .wdata(pwdata[15:0]), .q(outBPwr_q));
  cfg_field #(.W(2), .LSB(0), .RST(RST_SEL)) uBSel (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_OUT_BSEL]),
    .wdata(pwdata[15:0]), .q(outBSel_q));

  // ----------------------------------------
  // Input pin fields
  // ----------------------------------------
  // pin ignore bit
  cfg_field #(.W(1), .LSB(POS_PIN_IGN), .RST(RST_PIN_IGN)) uIgn (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_PIN_CFG]),
    .wdata(pwdata[15:0]), .q(pinIgn_q));
  cfg_field #(.W(1), .LSB(POS_PIN_HYST), .RST(1'h0)) uHyst (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_PIN_CFG]),
    .wdata(pwdata[15:0]), .q(pinHyst_q));
  cfg_field #(.W(2), .LSB(POS_PIN_LVL), .RST(2'h0)) uLvl (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_PIN_CFG]),
    .wdata(pwdata[15:0]), .q(pinLvl_q));
  cfg_field #(.W(3), .LSB(POS_PIN_FMT), .RST(3'h0)) uFmt (
    .mclk(mclk), .resetn(resetn), .we(wrIdx[IX_PIN_CFG]),
    .wdata(pwdata[15:0]), .q(pinFmt_q));

  // ----------------------------------------
  // Effective configuration
  // ----------------------------------------
  // pins used only when valid
  assign pinsLive = !pinIgn_q && phaseSyncMode && (pinFmt_q <= FMT_MAX);

  always_comb begin
    cfg_d = '0;
    cfg_d.feedbackDivide = {nHi_q, nLo_q};
    cfg_d.fractionDenominator = {denHi_q, denLo_q};
    cfg_d.modulatorRun = modRun_q;
    if (modRun_q && modOrder_q != 3'h0 && modOrder_q <= ORDER_MAX) begin
      cfg_d.modulatorOrder = modOrder_q;
      cfg_d.fractionNumerator = {numHi_q, numLo_q};
    end
    if (modRun_q && seedEn_q) begin
      cfg_d.modulatorSeed = seedAcc;
    end
    cfg_d.phaseDetectorDelaySelect = pfdDly_q;
    cfg_d.outAPowerLevel = outAPwr_q;
    cfg_d.outBPowerLevel = outBPwr_q;
    cfg_d.outAPowerdown = outAPd_q;
    cfg_d.outBPowerdown = outBPd_q;
    cfg_d.outputCurrentBoost = boost_q;
    cfg_d.outASourceSelect = outASel_q;
    if (outASel_q == SEL_SPECIAL && !doublerEnable) begin
      cfg_d.outASourceSelect = SEL_HIZ;
    end
    cfg_d.outBSourceSelect = outBSel_q;
    if (outBSel_q == SEL_SPECIAL && !sysrefOutputEnable) begin
      cfg_d.outBSourceSelect = SEL_HIZ;
    end
    cfg_d.inputPinHysteresis = pinHyst_q;
    cfg_d.inputPinBiasLevel = pinLvl_q;
    cfg_d.syncLvds = pinFmt_q[0];
    cfg_d.sysrefRequestLvds = pinFmt_q[1];
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      syncUsed_q <= 1'b0;
      sysrefReqUsed_q <= 1'b0;
    end else begin
      syncUsed_q <= syncPin && pinsLive;
      sysrefReqUsed_q <= sysrefRequestPin && pinsLive;
    end
  end

  assign synthCfg = cfg_q;
  assign syncUsed = syncUsed_q;
  assign sysrefRequestUsed = sysrefReqUsed_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div_reset_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(resetn) |-> ({nHi_q, nLo_q} == RST_N)
      && (pfdDly_q == RST_PFD_DLY))
    else $error("divide or delay not at reset value");

  seed_add_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wrIdx[IX_SEED_LOW] && modRun_q |=>
      seedAcc == $past(seedAcc) + {16'h0000, $past(pwdata[15:0])})
    else $error("seed write did not accumulate");

  seed_clear_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !modRun_q |=> seedAcc == 32'h00000000)
    else $error("seed not cleared by modulator reset");

  seed_gate_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !seedEn_q |=> cfg_q.modulatorSeed == 32'h00000000)
    else $error("seed applied while disabled");

  frac_ignore_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !modRun_q |=> cfg_q.fractionNumerator == 32'h00000000
      && cfg_q.modulatorOrder == 3'h0)
    else $error("fraction used while modulator reset");

  order_resv_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    modOrder_q > ORDER_MAX |=> cfg_q.modulatorOrder == 3'h0)
    else $error("reserved order reached output");

  outa_dbl_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    outASel_q == SEL_SPECIAL && !doublerEnable
      |=> cfg_q.outASourceSelect == SEL_HIZ)
    else $error("doubler routed without enable");

  pdown_b_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    $past(resetn) |-> cfg_q.outBPowerdown == $past(outBPd_q))
    else $error("output B powerdown not followed");

  pins_ign_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    pinIgn_q |=> !syncUsed_q && !sysrefReqUsed_q)
    else $error("input pin used while ignored");

  apb_wait_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    accessCyc && !pready_q |=> pready_q ##1 !pready_q)
    else $error("pready not a single pulse after wait");

endmodule // feedback_divider_mash_output_regs

// ### verif/feedback_divider_mash_output_regs_tb.sv
`timescale 1ns/100ps
module feedback_divider_mash_output_regs_tb;
  import fb_regs_pkg::*;

  // ----------
  // Signals
  // ----------
  typedef struct packed {logic [5:0] ix; logic [15:0] val;} row_s;
  logic mclk, resetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic pready, pslverr, rdErr;
  logic doublerEnable, sysrefOutputEnable, phaseSyncMode;
  logic syncPin, sysrefRequestPin, syncUsed, sysrefRequestUsed;
  synth_cfg_s synthCfg;
  int n_fail = 0;
  int n_compared = 0;
  row_s rows [18] = '{'{6'h22, 16'h0007}, '{6'h24, 16'hFFFF},
    '{6'h25, 16'hBF04}, '{6'h2C, 16'h2A64}, '{6'h2D, 16'hDEFF},
    '{6'h2E, 16'h07FF}, '{6'h3A, 16'hFE01}, '{6'h22, 16'h0005},
    '{6'h24, 16'h1234}, '{6'h25, 16'h0A04}, '{6'h26, 16'h1357},
    '{6'h27, 16'h9BDF}, '{6'h2A, 16'h2468}, '{6'h2B, 16'hACE0},
    '{6'h2C, 16'h1FA3}, '{6'h2D, 16'hC4D5}, '{6'h2E, 16'h07FE},
    '{6'h3A, 16'h7201}};
  row_s resetRows [13] = '{'{6'h22, 16'h0000}, '{6'h24, 16'h0064},
    '{6'h25, 16'h0204}, '{6'h26, 16'hFFFF}, '{6'h27, 16'hFFFF},
    '{6'h28, 16'h0000}, '{6'h29, 16'h0000}, '{6'h2A, 16'h0000},
    '{6'h2B, 16'h0000}, '{6'h2C, 16'h1FA0}, '{6'h2D, 16'hC8DF},
    '{6'h2E, 16'h07FD}, '{6'h3A, 16'h8001}};

  feedback_divider_mash_output_regs u_dut (
    .mclk(mclk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .doublerEnable(doublerEnable),
    .sysrefOutputEnable(sysrefOutputEnable),
    .phaseSyncMode(phaseSyncMode),
    .syncPin(syncPin),
    .sysrefRequestPin(sysrefRequestPin),
    .synthCfg(synthCfg),
    .syncUsed(syncUsed),
    .sysrefRequestUsed(sysrefRequestUsed)
  );

  // ----------
  // Tasks
  // ----------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
  endtask

  task automatic wr(input logic [5:0] ix, input logic [15:0] d);
    apb(1'b1, {ix, 2'b00}, d);
    cmp(rdErr, 1'b0);
  endtask

  task automatic rdc(input logic [5:0] ix, input logic [15:0] exp);
    apb(1'b0, {ix, 2'b00}, 16'h0000);
    cmp(rdVal, {16'h0000, exp});
    cmp(rdErr, 1'b0);
  endtask

  task automatic settle();
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    cmp(pready, 1'b0);
    cmp({31'h0, synthCfg !== '0}, 32'h0);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic close_out();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------
  // Clock and watchdog
  // ----------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out();
  end

  // ----------
  // Main sequence
  // ----------
  initial begin
    logic [1:0] sel, e;
    logic [2:0] fmt;
    logic ign, act, used;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    resetn = 1'b0;
    doublerEnable = 1'b0;
    sysrefOutputEnable = 1'b0;
    phaseSyncMode = 1'b0;
    syncPin = 1'b1;
    sysrefRequestPin = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].ix, rows[i].val);
      rdc(rows[i].ix, rows[i].val);
    end
    settle();
    cmp(synthCfg.feedbackDivide, 19'h51234);
    cmp(synthCfg.fractionDenominator, 32'h13579BDF);
    cmp(synthCfg.fractionNumerator, 32'h2468ACE0);
    cmp(synthCfg.modulatorOrder, 3'h3);
    cmp(synthCfg.modulatorRun, 1'b1);
    cmp(synthCfg.phaseDetectorDelaySelect, 6'h0A);
    cmp(synthCfg.outAPowerLevel, 6'h1F);
    cmp(synthCfg.outBPowerdown, 1'b1);
    cmp(synthCfg.outAPowerdown, 1'b0);
    cmp(synthCfg.outputCurrentBoost, 2'h2);
    cmp(synthCfg.outBPowerLevel, 6'h15);
    cmp(synthCfg.outBSourceSelect, SEL_HIZ);
    cmp(synthCfg.inputPinHysteresis, 1'b1);
    cmp(synthCfg.inputPinBiasLevel, 2'h3);
    for (int o = 0; o < 8; o++) begin
      wr(IX_OUT_MOD, 16'h1FA0 | {13'h0, o[2:0]});
      settle();
      act = (o >= 1 && o <= 4);
      cmp(synthCfg.fractionNumerator, act ? 32'h2468ACE0 : 32'h0);
      cmp(synthCfg.modulatorOrder, act ? o[2:0] : 3'h0);
    end
    wr(IX_OUT_MOD, 16'h2A43);
    settle();
    cmp(synthCfg.fractionNumerator, 32'h0);
    cmp(synthCfg.outAPowerLevel, 6'h2A);
    cmp(synthCfg.outBPowerdown, 1'b0);
    cmp(synthCfg.outAPowerdown, 1'b1);
    for (int c = 0; c < 8; c++) begin
      sel = c[1:0];
      doublerEnable <= c[2];
      sysrefOutputEnable <= c[2];
      wr(IX_OUT_ASEL, FIX_OUT_ASEL | {3'h0, sel, 11'h000});
      wr(IX_OUT_BSEL, FIX_OUT_BSEL | {14'h0, sel});
      settle();
      e = (sel == SEL_SPECIAL && !c[2]) ? SEL_HIZ : sel;
      cmp(synthCfg.outASourceSelect, e);
      cmp(synthCfg.outBSourceSelect, e);
    end
    for (int f = 0; f < 10; f++) begin
      ign = (f == 8);
      fmt = f[2:0];
      phaseSyncMode <= (f != 9);
      wr(IX_PIN_CFG, {ign, 3'h0, fmt, 9'h001});
      settle();
      used = !ign && f != 9 && fmt <= FMT_MAX;
      cmp(syncUsed, used);
      cmp(sysrefRequestUsed, used);
      if (fmt <= FMT_MAX) begin
        cmp(synthCfg.syncLvds, fmt[0]);
        cmp(synthCfg.sysrefRequestLvds, fmt[1]);
      end
    end
    // Pins live: each pin level must pass through on its own output
    phaseSyncMode <= 1'b1;
    wr(IX_PIN_CFG, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      syncPin <= p[0];
      sysrefRequestPin <= !p[0];
      settle();
      cmp(syncUsed, p[0]);
      cmp(sysrefRequestUsed, !p[0]);
    end
    wr(IX_SEED_LOW, 16'h0055);
    rdc(IX_SEED_LOW, 16'h0000);
    wr(IX_OUT_MOD, 16'h1FA3);
    wr(IX_SEED_LOW, 16'hFFFF);
    wr(IX_SEED_LOW, 16'h0001);
    rdc(IX_SEED_HIGH, 16'h0001);
    rdc(IX_SEED_LOW, 16'h0000);
    wr(IX_SEED_HIGH, 16'h0002);
    rdc(IX_SEED_HIGH, 16'h0003);
    settle();
    cmp(synthCfg.modulatorSeed, 32'h0);
    wr(IX_SEED_CTL, 16'h8A04);
    settle();
    cmp(synthCfg.modulatorSeed, 32'h00030000);
    wr(IX_OUT_MOD, 16'h1F83);
    wr(IX_OUT_MOD, 16'h1FA3);
    rdc(IX_SEED_HIGH, 16'h0000);
    // Unmapped index and misaligned address are refused
    apb(1'b0, {6'h23, 2'b00}, 16'h0000);
    cmp(rdErr, 1'b1);
    cmp(rdVal, 32'h0);
    apb(1'b1, 8'h91, 16'hBEEF);
    cmp(rdErr, 1'b1);
    rdc(IX_FB_LOW, 16'h1234);
    settle();
    do_reset();
    cmp(synthCfg.feedbackDivide, RST_N);
    cmp(synthCfg.fractionDenominator, RST_DEN);
    cmp(synthCfg.outASourceSelect, RST_SEL);
    foreach (resetRows[i]) begin
      rdc(resetRows[i].ix, resetRows[i].val);
    end
    settle();
    close_out();
  end

endmodule // feedback_divider_mash_output_regs_tb
